// *** core/vout_status_pkg.sv ***
// shared constants for the output target and fault summary register slice
package vout_status_pkg;

    // command codes on the management bus
    localparam logic [7:0]  CMD_CLEAR_FAULTS   = 8'h03;
    localparam logic [7:0]  CMD_SCALE_FORMAT   = 8'h20;
    localparam logic [7:0]  CMD_VOLTAGE_TARGET = 8'h21;
    localparam logic [7:0]  CMD_UPPER_MARGIN   = 8'h25;
    localparam logic [7:0]  CMD_LOWER_MARGIN   = 8'h26;
    localparam logic [7:0]  CMD_FAULT_BYTE     = 8'h78;
    localparam logic [7:0]  CMD_FAULT_WORD_HI  = 8'h79;

    // scale format: linear mode 000, exponent 10111 (-9)
    localparam logic [2:0]  SCALE_MODE_LINEAR  = 3'h0;
    localparam logic [4:0]  SCALE_EXPONENT     = 5'h17;
    localparam logic [15:0] SCALE_FORMAT_WORD  = {8'h00, SCALE_MODE_LINEAR, SCALE_EXPONENT};

    // target registers keep 12 bits, the top nibble reads zero
    localparam int          TARGET_W           = 12;
    localparam int          STRAP_W            = 10;
    localparam logic [1:0]  STRAP_PAD          = 2'h0;
    localparam logic [3:0]  TARGET_HI_PAD      = 4'h0;
    localparam logic [11:0] VOUT_CODE_MIN      = 12'h133;
    localparam logic [11:0] VOUT_CODE_MAX      = 12'h266;

    // margin select field codes
    localparam logic [3:0]  MARGIN_LOW_IGNORE  = 4'h5;
    localparam logic [3:0]  MARGIN_LOW_ACT     = 4'h6;
    localparam logic [3:0]  MARGIN_HIGH_IGNORE = 4'h9;
    localparam logic [3:0]  MARGIN_HIGH_ACT    = 4'hA;

    // latched event vector positions
    localparam int          EV_VOUT_OV   = 0;
    localparam int          EV_VOUT_WARN = 1;
    localparam int          EV_IOUT_OC   = 2;
    localparam int          EV_INPUT_UV  = 3;
    localparam int          EV_BIAS_UV   = 4;
    localparam int          EV_TEMP      = 5;
    localparam int          EV_CML       = 6;
    localparam int          EV_OTHER     = 7;
    localparam int          EV_W         = 8;

    // fault summary byte positions
    localparam int          FSB_OFF      = 6;
    localparam int          FSB_VOUT_OV  = 5;
    localparam int          FSB_IOUT_OC  = 4;
    localparam int          FSB_UV       = 3;
    localparam int          FSB_TEMP     = 2;
    localparam int          FSB_CML      = 1;
    localparam int          FSB_OTHER    = 0;

    // fault summary high byte positions
    localparam int          FSH_VOUT     = 7;
    localparam int          FSH_IOUT     = 6;
    localparam int          FSH_BIAS     = 5;
    localparam int          FSH_POWER_GOOD_FLAG_N_N  = 3;

    // slew interval: base time times a power of two chosen by the pin
    localparam int          CLOCK_MHZ         = 100;
    localparam int          SLEW_BASE_US      = 4;
    localparam int          SLEW_BASE_CYCLES  = SLEW_BASE_US * CLOCK_MHZ;
    localparam int          SLEW_MAX_SHIFT    = 3;

    typedef enum logic [1:0] {
        SEL_NOMINAL = 2'b00,
        SEL_LOW     = 2'b01,
        SEL_HIGH    = 2'b10
    } target_sel_t;

    typedef enum logic {
        LINK_IDLE = 1'b0,
        LINK_BUSY = 1'b1
    } link_state_t;

endpackage : vout_status_pkg

// *** core/slew_stepper.sv ***
// steps the applied output code toward the selected target, one code per slew interval
`timescale 1ns/10ps
`default_nettype none

module slew_stepper
    import vout_status_pkg::*;
#(
    parameter int CODE_W      = TARGET_W,
    parameter int BASE_CYCLES = SLEW_BASE_CYCLES,
    parameter int CNT_W       = 12
) (
    input  wire logic              i_clock,
    input  wire logic              i_srst,
    input  wire logic [CODE_W-1:0] i_target,
    input  wire logic [1:0]        i_slew_select,
    output var  logic [CODE_W-1:0] o_applied_code
);

    if ((BASE_CYCLES << SLEW_MAX_SHIFT) > (1 << CNT_W) || BASE_CYCLES < 1) begin : g_bad_cnt
        $error("slew_stepper: counter too narrow for the slew interval");
    end

    logic [CNT_W-1:0]  cnt_q, cnt_d, limit;
    logic [CODE_W-1:0] code_q, code_d;
    logic              primed_q, primed_d;

    always_comb begin
        limit    = CNT_W'((BASE_CYCLES << i_slew_select) - 1);
        cnt_d    = cnt_q;
        code_d   = code_q;
        primed_d = 1'b1;
        if (!primed_q) begin
            // first cycle after reset jumps straight to the strapped target
            code_d = i_target;
            cnt_d  = '0;
        end else if (cnt_q >= limit) begin
            cnt_d = '0;
            if (code_q < i_target) begin
                code_d = code_q + 1'b1; // [RULE_04]
            end else if (code_q > i_target) begin
                code_d = code_q - 1'b1; // [RULE_04]
            end
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            cnt_q    <= '0;
            code_q   <= CODE_W'(VOUT_CODE_MIN);
            primed_q <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            code_q   <= code_d;
            primed_q <= primed_d;
        end
    end

    assign o_applied_code = code_q;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    chk_step_on_tick: assert property ($past(primed_q) && code_q != $past(code_q) |-> cnt_q == '0) // [RULE_04]
        else $error("applied code moved away from a slew tick");
    chk_step_size_one: assert property ($past(primed_q) && code_q != $past(code_q)
        |-> (code_q == $past(code_q) + 1'b1) || (code_q == $past(code_q) - 1'b1)) // [RULE_04]
        else $error("applied code moved by more than one step");
    chk_applied_range: assert property ($past(primed_q, 2) |-> code_q >= CODE_W'(VOUT_CODE_MIN)
        && code_q <= CODE_W'(VOUT_CODE_MAX)) // [RULE_03]
        else $error("applied code left the usable range");
    cov_slew_up: cover property (primed_q && code_q < i_target ##1 code_q < i_target);

endmodule : slew_stepper

`default_nettype wire

// *** core/vout_target_and_fault_status_regs.sv ***
// output target and fault summary registers behind a link-clocked command port
//
// Functional notes
// RULE_01: scale format register is read-only: linear mode 000, exponent 10111 (-9).
// RULE_02: output target code is an unsigned mantissa times two to the minus nine.
// RULE_03: usable codes run 307 to 614; host keeps writes inside, device clamps.
// RULE_04: applied code moves one step per slew interval of 4, 8, 16 or 32 us.
// RULE_05: upper margin register is the target while high margin is selected.
// RULE_06: lower margin register is the target while low margin is selected.
// RULE_07: margin values travel as two data bytes in linear mantissa format.
// RULE_08: top nibble reads zero, ignores writes; the rest writable, reset from straps.
// RULE_09: off bit shows commanded off or output tri-stated by undervoltage, heat, lockout.
// RULE_10: overvoltage bit sets once an output overvoltage fault has occurred.
// RULE_11: overcurrent bit sets once an output overcurrent fault has occurred.
// RULE_12: undervoltage bit sets once an input or bias undervoltage has occurred.
// RULE_13: temperature bit sets once any temperature fault or warning has occurred.
// RULE_14: communication bit sets once a communication, memory or logic fault occurred.
// RULE_15: other bit sets for any remaining fault or warning; bit 7 reads zero. Here only i_other_event sets it, not an output voltage warning.
// RULE_16: margin field 0101/0110 picks low, 1001/1010 high, others the nominal target.
// RULE_17: clear faults drops every status bit at once and releases the alert output.
// RULE_18: a persisting fault sets again at once; clearing never restarts the converter.
// RULE_19: writes to read-only registers or fields leave the contents unchanged.
// RULE_20: high byte: output voltage bit 7, current 6, bias 5, inverted power good 3.
`timescale 1ns/10ps
`default_nettype none

module vout_target_and_fault_status_regs
    import vout_status_pkg::*;
#(
    parameter int BASE_CYCLES = SLEW_BASE_CYCLES
) (
    input  wire logic               i_clock,
    input  wire logic               i_srst,
    input  wire logic               i_link_clock,
    input  wire logic               i_link_strobe,
    input  wire logic               i_link_write,
    input  wire logic [7:0]         i_link_command,
    input  wire logic [15:0]        i_link_wdata,
    output var  logic [15:0]        o_link_rdata,
    output var  logic               o_link_done,
    output var  logic               o_link_busy,
    input  wire logic [3:0]         i_margin_select_field,
    input  wire logic               i_commanded_on,
    input  wire logic [STRAP_W-1:0] i_strap_target,
    input  wire logic [1:0]         i_slew_select,
    input  wire logic               i_vout_ov_fault,
    input  wire logic               i_vout_warning,
    input  wire logic               i_iout_oc_fault,
    input  wire logic               i_input_uv_fault,
    input  wire logic               i_bias_undervoltage_flag,
    input  wire logic               i_temp_event,
    input  wire logic               i_cml_fault,
    input  wire logic               i_other_event,
    input  wire logic               i_output_tristated,
    input  wire logic               i_power_good,
    output var  logic [TARGET_W-1:0] o_applied_code,
    output var  logic               o_alert_n
);

    if (BASE_CYCLES < 1) begin : g_bad_base
        $error("slew base interval must be at least one cycle");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    localparam int PIN_W = STRAP_W + 2 + 10;
    logic [PIN_W-1:0]   pins_s1_q, pins_s2_q;
    logic [STRAP_W-1:0] strap_s;
    logic [1:0]         slew_s;
    logic [EV_W-1:0]    ev_now;
    logic               tristated_s, power_good_flag_n_s;

    always_ff @(posedge i_clock) begin
        pins_s1_q <= {i_strap_target, i_slew_select, i_vout_ov_fault, i_vout_warning, i_iout_oc_fault,
                      i_input_uv_fault, i_bias_undervoltage_flag, i_temp_event, i_cml_fault, i_other_event,
                      i_output_tristated, i_power_good};
        pins_s2_q <= pins_s1_q;
    end

    assign {strap_s, slew_s, ev_now[EV_VOUT_OV], ev_now[EV_VOUT_WARN], ev_now[EV_IOUT_OC], ev_now[EV_INPUT_UV],
            ev_now[EV_BIAS_UV], ev_now[EV_TEMP], ev_now[EV_CML], ev_now[EV_OTHER], tristated_s, power_good_flag_n_s} = pins_s2_q;

    ////////////////////////////////////////////////////////////////////////////////
    // link domain: capture one request, hand it over by toggle, wait for the toggle back
    logic              lrst_s1_q, lrst_s2_q;
    link_state_t       lstate_q, lstate_d;
    logic              req_q, req_d, ack_seen_q, ack_seen_d;
    logic              lwr_q, lwr_d, done_q, done_d, busy_q, busy_d;
    logic [7:0]        lcmd_q, lcmd_d;
    logic [15:0]       lwdata_q, lwdata_d, lrdata_q, lrdata_d;
    logic              ack_s1_q, ack_s2_q;
    logic              ack_q, ack_d;
    logic [15:0]       rd_hold_q, rd_hold_d;

    always_comb begin
        lstate_d   = lstate_q;
        req_d      = req_q;
        ack_seen_d = ack_seen_q;
        lwr_d      = lwr_q;
        lcmd_d     = lcmd_q;
        lwdata_d   = lwdata_q;
        lrdata_d   = lrdata_q;
        done_d     = 1'b0;
        unique case (lstate_q)
            LINK_IDLE: begin
                if (i_link_strobe) begin
                    lwr_d    = i_link_write;
                    lcmd_d   = i_link_command;
                    lwdata_d = i_link_wdata; // [RULE_07]
                    req_d    = ~req_q;
                    lstate_d = LINK_BUSY;
                end
            end
            LINK_BUSY: begin
                if (ack_s2_q != ack_seen_q) begin
                    // read data settled on the same core edge that toggled the ack and holds until the next request
                    lrdata_d   = rd_hold_q;
                    ack_seen_d = ack_s2_q;
                    done_d     = 1'b1;
                    lstate_d   = LINK_IDLE;
                end
            end
        endcase
        busy_d = (lstate_d == LINK_BUSY);
    end

    always_ff @(posedge i_link_clock) begin
        lrst_s1_q <= i_srst;
        lrst_s2_q <= lrst_s1_q;
        ack_s1_q  <= ack_q;
        ack_s2_q  <= ack_s1_q;
        if (lrst_s2_q) begin
            lstate_q   <= LINK_IDLE;
            req_q      <= 1'b0;
            ack_seen_q <= 1'b0;
            lwr_q      <= 1'b0;
            lcmd_q     <= 8'h00;
            lwdata_q   <= 16'h0000;
            lrdata_q   <= 16'h0000;
            done_q     <= 1'b0;
            busy_q     <= 1'b0;
        end else begin
            lstate_q   <= lstate_d;
            req_q      <= req_d;
            ack_seen_q <= ack_seen_d;
            lwr_q      <= lwr_d;
            lcmd_q     <= lcmd_d;
            lwdata_q   <= lwdata_d;
            lrdata_q   <= lrdata_d;
            done_q     <= done_d;
            busy_q     <= busy_d;
        end
    end

    assign o_link_rdata = lrdata_q;
    assign o_link_done  = done_q;
    assign o_link_busy  = busy_q;

    ////////////////////////////////////////////////////////////////////////////////
    // core domain: registers, fault latches and read mux
    logic                req_s1_q, req_s2_q, req_seen_q;
    logic                exec, do_write, do_clear;
    logic [TARGET_W-1:0] nominal_q, nominal_d, upper_q, upper_d, lower_q, lower_d;
    logic [TARGET_W-1:0] wr_value, strap_value, target_raw, target_clamped;
    logic [EV_W-1:0]     latched_q, latched_d;
    logic [7:0]          fault_byte, fault_hi;
    logic                alert_n_q, alert_n_d;
    target_sel_t         target_sel;

    assign exec        = (req_s2_q != req_seen_q);
    assign do_write    = exec && lwr_q;
    assign do_clear    = do_write && (lcmd_q == CMD_CLEAR_FAULTS);
    assign wr_value    = lwdata_q[TARGET_W-1:0]; // [RULE_08]
    assign strap_value = {STRAP_PAD, strap_s}; // [RULE_08]

    // a live fault wins over a clear in the same cycle, so a persisting fault reads set again
    for (genvar e = 0; e < EV_W; e++) begin : g_latch
        assign latched_d[e] = ev_now[e] | (latched_q[e] & ~do_clear); // [RULE_17] [RULE_18]
    end

    always_comb begin
        fault_byte              = 8'h00; // [RULE_15]
        fault_byte[FSB_OFF]     = ~i_commanded_on | tristated_s; // [RULE_09]
        fault_byte[FSB_VOUT_OV] = latched_q[EV_VOUT_OV]; // [RULE_10]
        fault_byte[FSB_IOUT_OC] = latched_q[EV_IOUT_OC]; // [RULE_11]
        fault_byte[FSB_UV]      = latched_q[EV_INPUT_UV] | latched_q[EV_BIAS_UV]; // [RULE_12]
        fault_byte[FSB_TEMP]    = latched_q[EV_TEMP]; // [RULE_13]
        fault_byte[FSB_CML]     = latched_q[EV_CML]; // [RULE_14]
        fault_byte[FSB_OTHER]   = latched_q[EV_OTHER]; // [RULE_15]
        fault_hi                = 8'h00;
        fault_hi[FSH_VOUT]      = latched_q[EV_VOUT_OV] | latched_q[EV_VOUT_WARN]; // [RULE_20]
        fault_hi[FSH_IOUT]      = latched_q[EV_IOUT_OC]; // [RULE_20]
        fault_hi[FSH_BIAS]      = latched_q[EV_BIAS_UV]; // [RULE_20]
        fault_hi[FSH_POWER_GOOD_FLAG_N_N]   = ~power_good_flag_n_s; // [RULE_20]
    end

    always_comb begin
        nominal_d = nominal_q;
        upper_d   = upper_q;
        lower_d   = lower_q;
        rd_hold_d = rd_hold_q;
        ack_d     = ack_q;
        alert_n_d = alert_n_q;
        if (|ev_now) begin
            alert_n_d = 1'b0; // [RULE_18]
        end else if (do_clear) begin
            alert_n_d = 1'b1; // [RULE_17]
        end
        if (exec) begin
            ack_d = ~ack_q;
            if (lwr_q) begin
                // the scale format and status codes fall through untouched
                unique case (lcmd_q)
                    CMD_VOLTAGE_TARGET: nominal_d = wr_value; // [RULE_02] [RULE_08]
                    CMD_UPPER_MARGIN:   upper_d   = wr_value; // [RULE_07] [RULE_08]
                    CMD_LOWER_MARGIN:   lower_d   = wr_value; // [RULE_07] [RULE_08]
                    default:            ; // [RULE_19]
                endcase
            end else begin
                unique case (lcmd_q)
                    CMD_SCALE_FORMAT:   rd_hold_d = SCALE_FORMAT_WORD; // [RULE_01]
                    CMD_VOLTAGE_TARGET: rd_hold_d = {TARGET_HI_PAD, nominal_q}; // [RULE_08]
                    CMD_UPPER_MARGIN:   rd_hold_d = {TARGET_HI_PAD, upper_q};
                    CMD_LOWER_MARGIN:   rd_hold_d = {TARGET_HI_PAD, lower_q};
                    CMD_FAULT_BYTE:     rd_hold_d = {8'h00, fault_byte};
                    CMD_FAULT_WORD_HI:  rd_hold_d = {8'h00, fault_hi};
                    default:            rd_hold_d = 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge i_clock) begin
        req_s1_q <= req_q;
        req_s2_q <= req_s1_q;
        if (i_srst) begin
            // straps are two flops deep by the time reset is released
            nominal_q  <= strap_value;
            upper_q    <= strap_value;
            lower_q    <= strap_value;
            latched_q  <= '0;
            rd_hold_q  <= 16'h0000;
            ack_q      <= 1'b0;
            req_seen_q <= 1'b0;
            alert_n_q  <= 1'b1;
        end else begin
            nominal_q  <= nominal_d;
            upper_q    <= upper_d;
            lower_q    <= lower_d;
            latched_q  <= latched_d;
            rd_hold_q  <= rd_hold_d;
            ack_q      <= ack_d;
            req_seen_q <= req_s2_q;
            alert_n_q  <= alert_n_d;
        end
    end

    assign o_alert_n = alert_n_q;

    ////////////////////////////////////////////////////////////////////////////////
    // target selection and clamp; margins apply regardless of fault-ignore choice
    always_comb begin
        unique case (i_margin_select_field)
            MARGIN_LOW_IGNORE, MARGIN_LOW_ACT:   target_sel = SEL_LOW; // [RULE_16]
            MARGIN_HIGH_IGNORE, MARGIN_HIGH_ACT: target_sel = SEL_HIGH; // [RULE_16]
            default:                             target_sel = SEL_NOMINAL; // [RULE_16]
        endcase
        unique case (target_sel)
            SEL_LOW:  target_raw = lower_q; // [RULE_06]
            SEL_HIGH: target_raw = upper_q; // [RULE_05]
            default:  target_raw = nominal_q;
        endcase
        // out-of-range writes are the host's fault; the converter never sees them
        if (target_raw < VOUT_CODE_MIN) begin
            target_clamped = VOUT_CODE_MIN; // [RULE_03]
        end else if (target_raw > VOUT_CODE_MAX) begin
            target_clamped = VOUT_CODE_MAX; // [RULE_03]
        end else begin
            target_clamped = target_raw;
        end
    end

    slew_stepper #(
        .CODE_W      (TARGET_W),
        .BASE_CYCLES (BASE_CYCLES),
        .CNT_W       (12)
    ) u_stepper (
        .i_clock        (i_clock),
        .i_srst         (i_srst),
        .i_target       (target_clamped),
        .i_slew_select  (slew_s),
        .o_applied_code (o_applied_code)
    );

    ////////////////////////////////////////////////////////////////////////////////
    chk_scale_read: assert property (@(posedge i_clock) disable iff (i_srst)
        exec && !lwr_q && lcmd_q == CMD_SCALE_FORMAT |=> rd_hold_q == SCALE_FORMAT_WORD && ack_q != $past(ack_q)) // [RULE_01]
        else $error("scale format read returned a wrong word");
    chk_target_write: assert property (@(posedge i_clock) disable iff (i_srst)
        do_write && lcmd_q == CMD_VOLTAGE_TARGET |=> nominal_q == $past(lwdata_q[11:0])) // [RULE_08]
        else $error("target write did not store the low twelve bits");
    chk_ro_ignored: assert property (@(posedge i_clock) disable iff (i_srst)
        do_write && (lcmd_q == CMD_SCALE_FORMAT || lcmd_q == CMD_FAULT_BYTE)
        |=> $stable(nominal_q) && $stable(upper_q) && $stable(lower_q)) // [RULE_19]
        else $error("write to a read-only code changed a register");
    chk_clear_all: assert property (@(posedge i_clock) disable iff (i_srst)
        do_clear && ev_now == '0 |=> latched_q == '0 && o_alert_n) // [RULE_17]
        else $error("clear faults left a status bit or the alert set");
    chk_persist_set: assert property (@(posedge i_clock) disable iff (i_srst)
        ev_now[EV_VOUT_OV] |=> latched_q[EV_VOUT_OV] && !o_alert_n) // [RULE_18]
        else $error("persisting overvoltage did not read set");
    chk_sticky_hold: assert property (@(posedge i_clock) disable iff (i_srst)
        latched_q[EV_TEMP] && !do_clear |=> latched_q[EV_TEMP]) // [RULE_13]
        else $error("temperature bit dropped without a clear");
    chk_margin_high: assert property (@(posedge i_clock) disable iff (i_srst)
        i_margin_select_field == MARGIN_HIGH_ACT && upper_q == 12'h250 |-> target_clamped == 12'h250) // [RULE_05]
        else $error("high margin did not select the upper target");
    chk_margin_low: assert property (@(posedge i_clock) disable iff (i_srst)
        i_margin_select_field == MARGIN_LOW_IGNORE && lower_q == 12'h140 |-> target_clamped == 12'h140) // [RULE_06]
        else $error("low margin did not select the lower target");
    chk_off_bit: assert property (@(posedge i_clock) disable iff (i_srst)
        !i_commanded_on |-> fault_byte[FSB_OFF] && !fault_byte[7]) // [RULE_09]
        else $error("off bit clear while commanded off");
    chk_done_pulse: assert property (@(posedge i_link_clock) disable iff (lrst_s2_q)
        o_link_done |-> !o_link_busy ##1 !o_link_done) // [RULE_07]
        else $error("link done lasted more than one cycle");

    cov_clear_live: cover property (@(posedge i_clock) disable iff (i_srst) do_clear && |ev_now);
    cov_margin_hi: cover property (@(posedge i_clock) disable iff (i_srst) target_sel == SEL_HIGH);
    cov_status_rd: cover property (@(posedge i_clock) disable iff (i_srst)
        exec && !lwr_q && lcmd_q == CMD_FAULT_BYTE);

endmodule : vout_target_and_fault_status_regs

`default_nettype wire

// *** verif/link_host.sv ***
// link host model: one request at a time on the link request port
`timescale 1ns/10ps
`default_nettype none

module link_host (
    input  wire logic        i_link_clock,
    input  wire logic        i_link_done,
    input  wire logic [15:0] i_link_rdata,
    output var  logic        o_strobe,
    output var  logic        o_write,
    output var  logic [7:0]  o_command,
    output var  logic [15:0] o_wdata
);
    initial begin
        o_strobe = 1'b0;
        o_write = 1'b0;
        o_command = 8'hFF;
        o_wdata = 16'hFFFF;
    end

    // both bytes of the word travel on every access
    task xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] r);
        int n;
        @(negedge i_link_clock);
        o_strobe = 1'b1;
        o_write = w;
        o_command = c;
        o_wdata = d;
        @(negedge i_link_clock);
        // released command and data lines show the inverse so a stale value never passes
        o_strobe = 1'b0;
        o_command = ~c;
        o_wdata = ~d;
        for (n = 0; n < 20 && i_link_done !== 1'b1; n++) @(negedge i_link_clock);
        r = (i_link_done === 1'b1) ? i_link_rdata : 16'hXXXX;
    endtask : xfer
endmodule : link_host
`default_nettype wire

// *** verif/vout_target_and_fault_status_regs_tb.sv ***
// bench for the output target and fault summary registers
`timescale 1ns/10ps
`default_nettype none

module vout_target_and_fault_status_regs_tb;
    import vout_status_pkg::*;
    logic        i_clock = 1'b0;
    logic        i_link_clock = 1'b0;
    logic        i_srst = 1'b1;
    logic [3:0]  margin = 4'h0;
    logic        on = 1'b1;
    logic        tri_st = 1'b0;
    logic        power_good_flag_n = 1'b1;
    logic [1:0]  slew = 2'h0;
    logic [7:0]  flt = 8'h00;
    logic        strobe, write, done, busy, alert_n;
    logic [7:0]  cmd;
    logic [15:0] wdata, rdata;
    logic [11:0] applied;
    int          errors = 0;
    int          samples_checked = 0;
    logic [7:0]  fsb [8] = '{8'h20, 8'h00, 8'h10, 8'h08, 8'h08, 8'h04, 8'h02, 8'h01};
    logic [7:0]  fsh [8] = '{8'h80, 8'h80, 8'h40, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
    logic [15:0] mt [5] = '{16'h9250, 16'hA250, 16'h5140, 16'h6140, 16'h3180};

    always #5 i_clock = ~i_clock;
    initial begin
        #1.7;
        forever #3 i_link_clock = ~i_link_clock;
    end

    vout_target_and_fault_status_regs #(.BASE_CYCLES(4)) u_dut (
        .i_clock(i_clock), .i_srst(i_srst), .i_link_clock(i_link_clock), .i_link_strobe(strobe),
        .i_link_write(write), .i_link_command(cmd), .i_link_wdata(wdata), .o_link_rdata(rdata),
        .o_link_done(done), .o_link_busy(busy), .i_margin_select_field(margin), .i_commanded_on(on),
        .i_strap_target(10'h155), .i_slew_select(slew), .i_vout_ov_fault(flt[EV_VOUT_OV]),
        .i_vout_warning(flt[EV_VOUT_WARN]), .i_iout_oc_fault(flt[EV_IOUT_OC]), .i_input_uv_fault(flt[EV_INPUT_UV]),
        .i_bias_undervoltage_flag(flt[EV_BIAS_UV]), .i_temp_event(flt[EV_TEMP]), .i_cml_fault(flt[EV_CML]),
        .i_other_event(flt[EV_OTHER]), .i_output_tristated(tri_st), .i_power_good(power_good_flag_n),
        .o_applied_code(applied), .o_alert_n(alert_n));

    link_host u_host (.i_link_clock(i_link_clock), .i_link_done(done), .i_link_rdata(rdata),
        .o_strobe(strobe), .o_write(write), .o_command(cmd), .o_wdata(wdata));

    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] r;
        u_host.xfer(1'b0, c, 16'h0000, r);
        chk(r, e);
    endtask : rd
    task wr(input logic [7:0] c, input logic [15:0] d);
        logic [15:0] r;
        u_host.xfer(1'b1, c, d, r);
    endtask : wr
    task wait_core(input int n);
        repeat (n) @(negedge i_clock);
    endtask : wait_core
    task close_out;
        if (errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out

    initial begin
        #400000;
        errors++;
        close_out();
    end

    initial begin
        wait_core(20);
        i_srst = 1'b0;
        wait_core(10);
        rd(CMD_SCALE_FORMAT, SCALE_FORMAT_WORD);
        rd(CMD_VOLTAGE_TARGET, 16'h0155);
        chk({4'h0, applied}, 16'h0155);
        wr(CMD_SCALE_FORMAT, 16'h00FF);
        rd(CMD_SCALE_FORMAT, SCALE_FORMAT_WORD);
        rd(8'h22, 16'h0000);
        wr(CMD_VOLTAGE_TARGET, 16'hF180);
        wr(CMD_UPPER_MARGIN, 16'hF250);
        wr(CMD_LOWER_MARGIN, 16'h0140);
        rd(CMD_VOLTAGE_TARGET, 16'h0180);
        rd(CMD_UPPER_MARGIN, 16'h0250);
        rd(CMD_LOWER_MARGIN, 16'h0140);
        wait_core(300);
        chk({4'h0, applied}, 16'h0180);
        @(negedge i_clock) margin = 4'h9;
        wait_core(20);
        // one code per 4 cycles: only a few steps can have been taken
        chk({15'h0, applied > 12'h180 && applied < 12'h18C}, 16'h0001);
        for (int i = 0; i < 5; i++) begin
            @(negedge i_clock) margin = mt[i][15:12];
            wait_core(1500);
            chk({4'h0, applied}, {4'h0, mt[i][11:0]});
        end
        @(negedge i_clock) slew = 2'h3;
        wr(CMD_VOLTAGE_TARGET, 16'h0100);
        wait_core(320);
        // slowest interval: ten or eleven steps, where the fastest would reach the floor
        chk({15'h0, applied > 12'h172 && applied < 12'h178}, 16'h0001);
        @(negedge i_clock) slew = 2'h0;
        wait_core(1500);
        chk({4'h0, applied}, {4'h0, VOUT_CODE_MIN});
        wr(CMD_CLEAR_FAULTS, 16'h0000);
        for (int i = 0; i < EV_W; i++) begin
            @(negedge i_clock) flt = 8'h01 << i;
            wait_core(10);
            chk({15'h0, alert_n}, 16'h0000);
            rd(CMD_FAULT_BYTE, {8'h00, fsb[i]});
            rd(CMD_FAULT_WORD_HI, {8'h00, fsh[i]});
            wr(CMD_CLEAR_FAULTS, 16'h0000);
            rd(CMD_FAULT_BYTE, {8'h00, fsb[i]});
            @(negedge i_clock) flt = 8'h00;
            wait_core(10);
            wr(CMD_CLEAR_FAULTS, 16'h0000);
            rd(CMD_FAULT_BYTE, 16'h0000);
            chk({15'h0, alert_n}, 16'h0001);
        end
        @(negedge i_clock) on = 1'b0;
        wait_core(10);
        rd(CMD_FAULT_BYTE, 16'h0040);
        @(negedge i_clock) on = 1'b1;
        tri_st = 1'b1;
        power_good_flag_n = 1'b0;
        wait_core(10);
        rd(CMD_FAULT_BYTE, 16'h0040);
        rd(CMD_FAULT_WORD_HI, 16'h0008);
        close_out();
    end
endmodule : vout_target_and_fault_status_regs_tb
`default_nettype wire
